//--- logic/rotor_sampling_map.svh
// Behaviour
// - ignore samples 3 us after comparator on
// - tachogenerator capture sixth cycle after toggle
// - off-time capture three cycles after phase on
// - off-time state bit one cycle after
// - sampling-tick zero-cross one tick plus three
// - demag capture one tick plus three cycles
// - on-time state bit after delay plus one
// - on-time capture after delay plus three
// - on-time tick capture delay, tick, three
// - threshold code rises monotonically 000 to 110
`ifndef ROTOR_SAMPLING_MAP_SVH
`define ROTOR_SAMPLING_MAP_SVH

// clock and start-up filter timing
`define CLK_PERIOD_NS   5
`define STARTUP_NS      3000
`define STARTUP_CYC     ((`STARTUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STARTUP_W       10

// latencies in motor timer clock cycles
`define TACHO_LAT       4
`define Z_LAT           3
`define D_LAT           3

// widths
`define PHASE_W         6
`define DS_W            4
`define TB_W            16
`define THR_W           10
`define SEL_W           3

// reset values
`define TB_RESET        16'h0000
`define THR_RESET       10'h000

// threshold fractions of supply, in thousandths
`define THR_000         10'h028
`define THR_001         10'h078
`define THR_010         10'h0c8
`define THR_011         10'h12c
`define THR_100         10'h190
`define THR_101         10'h1f4
`define THR_110         10'h2bc

`endif

//--- logic/rotor_sampling_pkg.sv
package rotor_sampling_pkg;

  // how and when the comparator is sampled
  typedef enum logic [2:0] {
    MODE_TACHO,
    MODE_OFF_TIME,
    MODE_TICK,
    MODE_ON_DELAY,
    MODE_ON_DELAY_TICK
  } mode_t;

  // sequencer for delayed sampling
  typedef enum logic [1:0] {
    SAMP_IDLE,
    SAMP_DELAY,
    SAMP_WAIT_TICK
  } sampler_state_t;

endpackage

//--- logic/rotor_position_sampling.sv
`timescale 1ns/1ps
`include "rotor_sampling_map.svh"

module rotor_position_sampling (
  // clocking
  input  wire logic                         clock,
  input  wire logic                         resetn,
  input  wire logic                         clockEnable,
  // comparator output and inverter phase outputs
  input  wire logic                         positionSenseInput,
  input  wire logic [`PHASE_W-1:0]          phasePwmOutput,
  // comparator configuration
  input  wire logic                         comparatorClockEnable,
  input  wire logic                         referenceGenEnable,
  input  wire logic [`SEL_W-1:0]            referenceThresholdSelect,
  // sampling configuration
  input  wire rotor_sampling_pkg::mode_t    samplingMode,
  input  wire logic [`DS_W-1:0]             samplingDelayField,
  input  wire logic                         demagEnable,
  input  wire logic                         sampleTick,
  // timebase
  input  wire logic [`TB_W-1:0]             motorTimebaseCounter,
  // results
  output logic                              sampledComparatorState,
  output logic                              zeroCrossEvent,
  output logic [`TB_W-1:0]                  zeroCrossCaptureReg,
  output logic                              demagEvent,
  output logic [`TB_W-1:0]                  demagCaptureReg,
  output logic                              comparatorReady,
  output logic [`THR_W-1:0]                 thresholdPermille
);

  // threshold fraction for a select code; 111 is unused and saturates
  function automatic logic [`THR_W-1:0] thresholdOf(
    input logic [`SEL_W-1:0] code
  );
    logic [`THR_W-1:0] value;
    value = `THR_110;
    case (code)
      3'h0: value = `THR_000;
      3'h1: value = `THR_001;
      3'h2: value = `THR_010;
      3'h3: value = `THR_011;
      3'h4: value = `THR_100;
      3'h5: value = `THR_101;
      default: value = `THR_110;
    endcase
    return value;
  endfunction

  // ------------------------------------------------------------
  // input synchronisation and edge detection
  logic                  compMeta;
  logic                  compSync;
  logic                  compPrev;
  logic [`PHASE_W-1:0]   phasePrev;
  logic                  next_compMeta;
  logic                  next_compSync;
  logic                  next_compPrev;
  logic [`PHASE_W-1:0]   next_phasePrev;
  logic                  compToggle;
  logic                  phaseRise;

  always_comb begin
    next_compMeta  = positionSenseInput;
    next_compSync  = compMeta;
    next_compPrev  = compSync;
    next_phasePrev = phasePwmOutput;
  end

  // synchroniser and previous-value registers
  always_ff @(posedge clock) begin
    if (!resetn) begin
      compMeta  <= 1'b0;
      compSync  <= 1'b0;
      compPrev  <= 1'b0;
      phasePrev <= '0;
    end else if (clockEnable) begin
      compMeta  <= next_compMeta;
      compSync  <= next_compSync;
      compPrev  <= next_compPrev;
      phasePrev <= next_phasePrev;
    end
  end

  // edges only look at the second stage, never at compMeta
  assign compToggle = compSync ^ compPrev;
  // any phase output turning on counts as the sampling trigger
  assign phaseRise  = |(phasePwmOutput & ~phasePrev);

  // ------------------------------------------------------------
  // start-up filter after the comparator is switched on
  logic                  compOn;
  logic [`STARTUP_W-1:0] startupCount;
  logic                  next_compOn;
  logic [`STARTUP_W-1:0] next_startupCount;
  logic                  next_comparatorReady;
  logic [`THR_W-1:0]     next_thresholdPermille;
  logic                  samplingAllowed;

  always_comb begin
    next_compOn       = comparatorClockEnable | referenceGenEnable;
    next_startupCount = startupCount;
    if (next_compOn && !compOn) begin
      next_startupCount = `STARTUP_W'(`STARTUP_CYC);
    end else if (!next_compOn) begin
      next_startupCount = '0;         // off: no filter pending
    end else if (startupCount != '0) begin
      next_startupCount = startupCount - 1'b1;
    end
    next_comparatorReady   = next_compOn && (next_startupCount == '0);
    next_thresholdPermille = thresholdOf(referenceThresholdSelect);
  end

  // filter counter, ready flag and threshold output
  always_ff @(posedge clock) begin
    if (!resetn) begin
      compOn            <= 1'b0;
      startupCount      <= '0;
      comparatorReady   <= 1'b0;
      thresholdPermille <= `THR_RESET;
    end else if (clockEnable) begin
      compOn            <= next_compOn;
      startupCount      <= next_startupCount;
      comparatorReady   <= next_comparatorReady;
      thresholdPermille <= next_thresholdPermille;
    end
  end

  // registered ready keeps the gate glitch free at the cost of a cycle
  assign samplingAllowed = comparatorReady;

  // ------------------------------------------------------------
  // sampling sequencer
  rotor_sampling_pkg::sampler_state_t state;
  rotor_sampling_pkg::sampler_state_t next_state;
  logic [`DS_W-1:0]      delayLeft;
  logic [`DS_W-1:0]      next_delayLeft;
  logic                  tickLast;
  logic                  next_tickLast;
  logic                  next_sampledComparatorState;
  logic                  hstLaunch;
  logic                  zLaunch;
  logic                  dLaunch;
  logic                  tachoLaunch;

  // launch decode per mode; filter gate overrides every launch
  always_comb begin
    next_state     = state;
    next_delayLeft = delayLeft;
    next_tickLast  = tickLast;
    hstLaunch      = 1'b0;
    dLaunch        = 1'b0;
    tachoLaunch    = 1'b0;
    case (state)
      rotor_sampling_pkg::SAMP_IDLE: begin
        case (samplingMode)
          rotor_sampling_pkg::MODE_TACHO: begin
            tachoLaunch = compToggle;
          end
          rotor_sampling_pkg::MODE_OFF_TIME: begin
            hstLaunch = phaseRise;
          end
          rotor_sampling_pkg::MODE_TICK: begin
            hstLaunch = sampleTick;
          end
          rotor_sampling_pkg::MODE_ON_DELAY,
          rotor_sampling_pkg::MODE_ON_DELAY_TICK: begin
            if (phaseRise) begin
              if (samplingDelayField != '0) begin
                next_state     = rotor_sampling_pkg::SAMP_DELAY;
                next_delayLeft = samplingDelayField - 1'b1;
              end else if (samplingMode ==
                           rotor_sampling_pkg::MODE_ON_DELAY_TICK) begin
                next_state = rotor_sampling_pkg::SAMP_WAIT_TICK;
              end else begin
                hstLaunch = 1'b1;     // zero delay acts like off-time
              end
            end
          end
          default: begin
            next_state = rotor_sampling_pkg::SAMP_IDLE;
          end
        endcase
      end
      rotor_sampling_pkg::SAMP_DELAY: begin
        if (delayLeft != '0) begin
          next_delayLeft = delayLeft - 1'b1;
        end else if (samplingMode ==
                     rotor_sampling_pkg::MODE_ON_DELAY_TICK) begin
          next_state = rotor_sampling_pkg::SAMP_WAIT_TICK;
        end else begin
          hstLaunch  = 1'b1;
          next_state = rotor_sampling_pkg::SAMP_IDLE;
        end
      end
      // after the delay wait one tick
      rotor_sampling_pkg::SAMP_WAIT_TICK: begin
        if (sampleTick) begin
          hstLaunch  = 1'b1;
          next_state = rotor_sampling_pkg::SAMP_IDLE;
        end
      end
      default: begin
        next_state = rotor_sampling_pkg::SAMP_IDLE;
      end
    endcase
    if (sampleTick) begin
      next_tickLast = compSync;
      dLaunch       = demagEnable && (compSync != tickLast);
    end
    if (!samplingAllowed) begin
      next_state  = rotor_sampling_pkg::SAMP_IDLE;
      hstLaunch   = 1'b0;
      dLaunch     = 1'b0;
      tachoLaunch = 1'b0;
    end
    // zero crossing is a change of the sampled state
    zLaunch = hstLaunch && (compSync != sampledComparatorState);
    next_sampledComparatorState =
      hstLaunch ? compSync : sampledComparatorState;
  end

  // sequencer state and sampled comparator bit
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state                  <= rotor_sampling_pkg::SAMP_IDLE;
      delayLeft              <= '0;
      tickLast               <= 1'b0;
      sampledComparatorState <= 1'b0;
    end else if (clockEnable) begin
      state                  <= next_state;
      delayLeft              <= next_delayLeft;
      tickLast               <= next_tickLast;
      sampledComparatorState <= next_sampledComparatorState;
    end
  end

  // ------------------------------------------------------------
  // event latency lines and timebase captures
  logic [`Z_LAT-2:0]     zPipe;
  logic [`D_LAT-2:0]     dPipe;
  logic [`TACHO_LAT-2:0] tachoPipe;
  logic [`Z_LAT-2:0]     next_zPipe;
  logic [`D_LAT-2:0]     next_dPipe;
  logic [`TACHO_LAT-2:0] next_tachoPipe;
  logic                  next_zeroCrossEvent;
  logic                  next_demagEvent;
  logic [`TB_W-1:0]      next_zeroCrossCaptureReg;
  logic [`TB_W-1:0]      next_demagCaptureReg;

  // shift registers rather than counters so back-to-back events overlap
  always_comb begin
    next_zPipe     = {zPipe[`Z_LAT-3:0], zLaunch};
    next_dPipe     = {dPipe[`D_LAT-3:0], dLaunch};
    next_tachoPipe = {tachoPipe[`TACHO_LAT-3:0], tachoLaunch};
    next_zeroCrossEvent      = 1'b0;
    next_demagEvent          = 1'b0;
    next_zeroCrossCaptureReg = zeroCrossCaptureReg;
    next_demagCaptureReg     = demagCaptureReg;
    if (zPipe[`Z_LAT-2] || tachoPipe[`TACHO_LAT-2]) begin
      next_zeroCrossEvent      = 1'b1;
      next_zeroCrossCaptureReg = motorTimebaseCounter;
    end
    if (dPipe[`D_LAT-2]) begin
      next_demagEvent      = 1'b1;
      next_demagCaptureReg = motorTimebaseCounter;
    end
  end

  // latency lines, event pulses and capture registers
  always_ff @(posedge clock) begin
    if (!resetn) begin
      zPipe               <= '0;
      dPipe               <= '0;
      tachoPipe           <= '0;
      zeroCrossEvent      <= 1'b0;
      demagEvent          <= 1'b0;
      zeroCrossCaptureReg <= `TB_RESET;
      demagCaptureReg     <= `TB_RESET;
    end else if (clockEnable) begin
      zPipe               <= next_zPipe;
      dPipe               <= next_dPipe;
      tachoPipe           <= next_tachoPipe;
      zeroCrossEvent      <= next_zeroCrossEvent;
      demagEvent          <= next_demagEvent;
      zeroCrossCaptureReg <= next_zeroCrossCaptureReg;
      demagCaptureReg     <= next_demagCaptureReg;
    end
  end

endmodule // rotor_position_sampling

//--- bench/comparator_model.sv
`timescale 1ns/1ps
`include "rotor_sampling_map.svh"

// comparator and inverter stand-in; slow answers use a larger PROP_NS
module comparator_model #(
  parameter int PROP_NS = 1
) (
  // requests from the bench
  input  wire logic                compLevel,
  input  wire logic [`PHASE_W-1:0] phaseReq,
  // far-side pins
  output wire logic                positionSenseInput,
  output wire logic [`PHASE_W-1:0] phasePwmOutput
);
  // comparator edge lands off the clock grid, so it is truly asynchronous
  assign #(PROP_NS) positionSenseInput = compLevel;
  assign phasePwmOutput = phaseReq;
endmodule // comparator_model

//--- bench/rotor_position_sampling_checker.sv
`timescale 1ns/1ps
`include "rotor_sampling_map.svh"

module rotor_position_sampling_checker (
  // clocking
  input wire logic                      clock,
  input wire logic                      resetn,
  input wire logic                      clockEnable,
  // comparator side and set-up
  input wire logic                      positionSenseInput,
  input wire logic [`PHASE_W-1:0]       phasePwmOutput,
  input wire logic                      comparatorClockEnable,
  input wire logic                      referenceGenEnable,
  input wire logic [`SEL_W-1:0]         referenceThresholdSelect,
  input wire rotor_sampling_pkg::mode_t samplingMode,
  input wire logic [`DS_W-1:0]          samplingDelayField,
  input wire logic [`TB_W-1:0]          motorTimebaseCounter,
  // results
  input wire logic                      sampledComparatorState,
  input wire logic                      zeroCrossEvent,
  input wire logic [`TB_W-1:0]          zeroCrossCaptureReg,
  input wire logic                      demagEvent,
  input wire logic [`TB_W-1:0]          demagCaptureReg,
  input wire logic                      comparatorReady,
  input wire logic [`THR_W-1:0]         thresholdPermille
);
  localparam logic [`THR_W-1:0] THR_TAB [8] = '{`THR_000, `THR_001,
    `THR_010, `THR_011, `THR_100, `THR_101, `THR_110, `THR_110};
  logic [9:0]          onCnt, next_onCnt;
  logic [4:0]          sinceRise, next_sinceRise;
  logic [`PHASE_W-1:0] prevPhase, next_prevPhase;
  logic                rise;

  // counters move on enabled edges only, as the design counts
  always_comb begin
    rise = clockEnable && |(phasePwmOutput & ~prevPhase);
    next_prevPhase = clockEnable ? phasePwmOutput : prevPhase;
    next_sinceRise = rise ? 5'd1 : sinceRise + 5'(clockEnable && ~&sinceRise);
    next_onCnt = onCnt + 10'(clockEnable && ~&onCnt);
    if (!(comparatorClockEnable || referenceGenEnable)) next_onCnt = '0;
  end
  always_ff @(posedge clock) begin
    onCnt <= resetn ? next_onCnt : '0;
    sinceRise <= resetn ? next_sinceRise : '0;
    prevPhase <= resetn ? next_prevPhase : '0;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence tachoToggle;
    clockEnable && comparatorReady && $changed(positionSenseInput) &&
      samplingMode == rotor_sampling_pkg::MODE_TACHO;
  endsequence
  sequence offEvt;
    zeroCrossEvent && samplingMode == rotor_sampling_pkg::MODE_OFF_TIME;
  endsequence

  // latencies are counted from the detecting edge
  a_ready_filter: assert property (
    $rose(comparatorReady) |-> onCnt == 10'(`STARTUP_CYC + 1))
    else $error("filter short");
  a_off_not_ready: assert property (
    clockEnable && !(comparatorClockEnable || referenceGenEnable)
      |=> !comparatorReady) else $error("ready while off");
  a_tacho_capture: assert property (
    tachoToggle |-> ##6 zeroCrossEvent) else $error("tacho event late");
  a_zero_capture: assert property (
    zeroCrossEvent && $past(clockEnable) |->
      zeroCrossCaptureReg == $past(motorTimebaseCounter))
    else $error("zero capture value");
  a_demag_capture: assert property (
    demagEvent && $past(clockEnable) |->
      demagCaptureReg == $past(motorTimebaseCounter))
    else $error("demag capture value");
  a_offtime_event: assert property (
    offEvt |-> sinceRise == 5'h03) else $error("off-time event timing");
  a_offtime_state: assert property (
    $changed(sampledComparatorState) &&
      samplingMode == rotor_sampling_pkg::MODE_OFF_TIME |-> sinceRise == 5'h01)
    else $error("off-time state timing");
  a_ondelay_event: assert property (
    zeroCrossEvent && samplingMode == rotor_sampling_pkg::MODE_ON_DELAY
      |-> sinceRise == {1'b0, samplingDelayField} + 5'h03)
    else $error("on-delay event timing");
  a_ondelay_state: assert property (
    $changed(sampledComparatorState) &&
      samplingMode == rotor_sampling_pkg::MODE_ON_DELAY
      |-> sinceRise == {1'b0, samplingDelayField} + 5'h01)
    else $error("on-delay state timing");
  a_thr_map: assert property (
    $past(resetn) && $past(clockEnable) |->
      thresholdPermille == THR_TAB[$past(referenceThresholdSelect)])
    else $error("threshold code map");
endmodule // rotor_position_sampling_checker

bind rotor_position_sampling rotor_position_sampling_checker
  rotor_position_sampling_checker_inst (.*);

//--- bench/rotor_position_sampling_test.sv
`timescale 1ns/1ps
`include "rotor_sampling_map.svh"

module rotor_position_sampling_test;
  logic clock = 1'b0, resetn = 1'b0, clockEnable = 1'b1, cke = 1'b0;
  logic dac = 1'b0, demagEnable = 1'b0, tick = 1'b0, compLevel = 1'b0;
  logic pin, state, zEv, dEv, ready;
  logic [`PHASE_W-1:0] phaseReq = '0, phase;
  logic [`SEL_W-1:0] sel = '0;
  logic [`DS_W-1:0] ds = '0;
  logic [`TB_W-1:0] tb = '0, zCap, dCap;
  logic [`THR_W-1:0] thr;
  logic [31:0] rnd = 32'hd414;
  rotor_sampling_pkg::mode_t mode = rotor_sampling_pkg::MODE_TACHO;
  int cyc = 0, miscompares = 0, nTests = 0, at, k, evs;
  int thrWant[8] = '{40, 120, 200, 300, 400, 500, 700, 700};
  int expZ[$];

  always #2.5 clock = ~clock;
  comparator_model comparator_model_inst (.compLevel(compLevel),
    .phaseReq(phaseReq), .positionSenseInput(pin), .phasePwmOutput(phase));
  rotor_position_sampling rotor_position_sampling_inst (.clock(clock),
    .resetn(resetn), .clockEnable(clockEnable), .positionSenseInput(pin),
    .phasePwmOutput(phase), .comparatorClockEnable(cke),
    .referenceGenEnable(dac), .referenceThresholdSelect(sel),
    .samplingMode(mode), .samplingDelayField(ds), .demagEnable(demagEnable),
    .sampleTick(tick), .motorTimebaseCounter(tb),
    .sampledComparatorState(state), .zeroCrossEvent(zEv),
    .zeroCrossCaptureReg(zCap), .demagEvent(dEv), .demagCaptureReg(dCap),
    .comparatorReady(ready), .thresholdPermille(thr));

  // result model: every zero-cross event must be one the rules predicted
  always @(posedge clock) begin
    #2;
    if (zEv === 1'b1) begin
      if (expZ.size() == 0) check(zCap, 32'hffff_ffff);
      else check(cyc, expZ.pop_front());
    end
  end

  // inputs move 1 ns after the edge; timebase mirrors the edge count
  task automatic step(int n = 1);
    repeat (n) begin
      @(posedge clock);
      #1;
      cyc++;
      tb = cyc[15:0];
    end
  endtask
  task automatic check(logic [31:0] seen, logic [31:0] want);
    nTests++;
    if (seen !== want) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  // galois step of the stimulus generator
  function automatic logic [31:0] lfsr(logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h0040_0007 : 32'h0);
  endfunction
  // bounded wait; at stays -1 when no event shows
  task automatic waitEv();
    at = -1;
    for (int i = 0; i < 40 && at < 0; i++) begin
      step();
      if (zEv === 1'b1) at = cyc;
    end
  endtask
  // toggles during warm-up must all be swallowed by the filter
  task automatic warmUp();
    k = cyc;
    at = -1;
    evs = 0;
    for (int i = 0; i < 700 && at < 0; i++) begin
      if (i % 50 == 1) compLevel = ~compLevel;
      step();
      if (zEv === 1'b1) evs++;
      if (ready === 1'b1) at = cyc;
    end
    check(at - k, `STARTUP_CYC + 1);
    check(evs, 0);
  endtask
  task automatic phaseRun(int lat, int frz);
    compLevel = ~compLevel;
    step(4);
    phaseReq[cyc % 6] = 1'b1;
    k = cyc;
    expZ.push_back(k + lat + frz);
    if (frz > 0) begin
      step();
      clockEnable = 1'b0;
      step(frz);
      clockEnable = 1'b1;
    end
    waitEv();
    check(at - k, lat + frz);
    check(state, compLevel);
    check(zCap, at - 1);
    phaseReq = '0;
    step(4);
  endtask
  // a reference tick first, so demag has a previous sample to compare
  task automatic tickRun(bit withPhase);
    tick = 1'b1;
    step();
    tick = 1'b0;
    step(6);
    compLevel = ~compLevel;
    step(4);
    if (withPhase) begin
      phaseReq[2] = 1'b1;
      step(ds + 3);
    end
    tick = 1'b1;
    k = cyc;
    expZ.push_back(k + `Z_LAT);
    step();
    tick = 1'b0;
    waitEv();
    check(at - k, `Z_LAT);
    check(zCap, at - 1);
    check(dEv, 1'b1);
    check(dCap, at - 1);
    phaseReq = '0;
    step(4);
  endtask
  task automatic testDone();
    $display("comparisons %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // the whole run is near 1450 cycles; ten thousand marks a hang
  initial begin
    #50000;
    miscompares++;
    testDone();
  end

  initial begin
    step(20);
    resetn = 1'b1;
    for (int c = 0; c < 8; c++) begin
      sel = c[2:0];
      step();
      check(thr, thrWant[c]);
    end
    cke = 1'b1;
    warmUp();
    cke = 1'b0;
    step(2);
    check(ready, 1'b0);
    dac = 1'b1;
    warmUp();
    repeat (4) begin
      compLevel = ~compLevel;
      k = cyc;
      expZ.push_back(k + `TACHO_LAT + 2);
      waitEv();
      check(at - k, `TACHO_LAT + 2);
      check(zCap, at - 1);
      step(3);
    end
    mode = rotor_sampling_pkg::MODE_OFF_TIME;
    phaseRun(`Z_LAT, 0);
    phaseRun(`Z_LAT, 3);
    phaseReq[1] = 1'b1;
    waitEv();
    check(at, -1);
    phaseReq = '0;
    mode = rotor_sampling_pkg::MODE_ON_DELAY;
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      // the middle run uses a zero delay, which acts as off-time sampling
      ds = (i == 0) ? 4'hf : (i == 1) ? 4'h0 : (rnd[3:0] | 4'h1);
      phaseRun(ds + `Z_LAT, 0);
    end
    demagEnable = 1'b1;
    mode = rotor_sampling_pkg::MODE_TICK;
    tickRun(1'b0);
    tickRun(1'b0);
    mode = rotor_sampling_pkg::MODE_ON_DELAY_TICK;
    tickRun(1'b1);
    check(expZ.size(), 0);
    testDone();
  end
endmodule // rotor_position_sampling_test
